// ===== pad_routing_defs.vh
`ifndef PAD_ROUTING_DEFS_VH
`define PAD_ROUTING_DEFS_VH

// Pad array geometry
`define PAD_COUNT 50
`define FSEL_W 3
`define FSEL_WAYS 8
`define PSIZE_W 2
`define PRES_W 4

// Function select codes used by the serial masters
`define FSEL_0 3'h0
`define FSEL_1 3'h1
`define FSEL_2 3'h2
`define FSEL_4 3'h4
`define FSEL_5 3'h5
`define FSEL_7 3'h7

// Pull-up size codes: 1.5k, 6k, 12k, 24k ohm
`define PSIZE_1K5 2'h0
`define PSIZE_6K 2'h1
`define PSIZE_12K 2'h2
`define PSIZE_24K 2'h3

// One-hot resistor select lines
`define PRES_1K5 4'h1
`define PRES_6K 4'h2
`define PRES_12K 4'h4
`define PRES_24K 4'h8
`define PRES_NONE 4'h0

// Reset values of the registered pad driver
`define PAD_OUT_RST 1'b0
`define PAD_OE_N_RST 1'b1

`endif

// ===== pad_cell.v
`timescale 1ns/100ps
`include "pad_routing_defs.vh"

module pad_cell (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Configuration
    input wire [`FSEL_W-1:0] pad_function_select,
    input wire pad_input_enable,
    input wire pad_pullup_enable,
    input wire [`PSIZE_W-1:0] pad_pullup_size,
    // Candidate module signals, one per select value
    input wire [`FSEL_WAYS-1:0] cand_data,
    input wire [`FSEL_WAYS-1:0] cand_en,
    input wire [`FSEL_WAYS-1:0] cand_od,
    // Pad side
    input wire pad_in,
    output reg pad_out_r,
    output reg pad_oe_n_r,
    output reg [`PRES_W-1:0] pad_pullup_res_r,
    output wire pad_in_gated
);

    reg pad_out_nxt;
    reg pad_oe_n_nxt;
    reg [`PRES_W-1:0] pad_pullup_res_nxt;
    wire sel_data;
    wire sel_en;
    wire sel_od;

    ////////////////////////////////////////////////////////////////////////
    // Eight-way selection of the module signal
    assign sel_data = cand_data[pad_function_select];
    assign sel_en = cand_en[pad_function_select];
    assign sel_od = cand_od[pad_function_select];

    // Disabled input reads as zero
    assign pad_in_gated = pad_in & pad_input_enable;

    ////////////////////////////////////////////////////////////////////////
    // Driver control: open drain, push-pull or released
    always @* begin
        if (!sel_en) begin
            pad_out_nxt = 1'b0;
            pad_oe_n_nxt = 1'b1;
        end else if (sel_od) begin
            pad_out_nxt = 1'b0;
            pad_oe_n_nxt = sel_data;
        end else begin
            pad_out_nxt = sel_data;
            pad_oe_n_nxt = 1'b0;
        end
    end

    // Pull-up resistor size decode
    always @* begin
        case (pad_pullup_size)
            `PSIZE_1K5: pad_pullup_res_nxt = `PRES_1K5;
            `PSIZE_6K: pad_pullup_res_nxt = `PRES_6K;
            `PSIZE_12K: pad_pullup_res_nxt = `PRES_12K;
            `PSIZE_24K: pad_pullup_res_nxt = `PRES_24K;
            default: pad_pullup_res_nxt = `PRES_NONE;
        endcase
        if (!pad_pullup_enable) begin
            pad_pullup_res_nxt = `PRES_NONE;
        end
    end

    // Registered pad driver
    always @(posedge sys_clk) begin
        if (rst) begin
            pad_out_r <= `PAD_OUT_RST;
            pad_oe_n_r <= `PAD_OE_N_RST;
            pad_pullup_res_r <= `PRES_NONE;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_n_r <= pad_oe_n_nxt;
            pad_pullup_res_r <= pad_pullup_res_nxt;
        end
    end

endmodule // pad_cell

// ===== serial_master_pad_routing.v
`timescale 1ns/100ps
`include "pad_routing_defs.vh"

// Operation
// - Select 0 on pads 5 and 6 routes master 0 SCL and SDA there.
// - Select 0 on pads 8 and 9 routes master 1 SCL and SDA there.
// - Master 2 two-wire on pads 0/1 at select 7, or 27/25 at 4.
// - Select 4 on pads 42 and 43 routes master 3 SCL and SDA.
// - Select 4 on pads 39 and 40 routes master 4 SCL and SDA.
// - Select 4 on pads 48 and 49 routes master 5 SCL and SDA.
// - Select 1 on pads 5,6,7 gives master 0 SPI clock, MISO, MOSI.
// - Master 0 has eight slave selects; pads 8,4,9,10 use value 2.
// - Select 1 on pads 8,9,10 gives master 1 SPI clock, MISO, MOSI.
// - Master 1 slave selects on listed pads, some with values 5,7,2.
// - Select 5 gives master 2 SPI on pads 0/27, 2/28, 1/25.
// - Master 2 slave selects on listed pads with values 4,5,0,2.
// - Select 5 on pads 42,43,38 gives master 3 SPI clock, MISO, MOSI.
// - Master 3 slave selects on pads 26,34,35,36,37,41,45,33.
// - Pull-up size codes 0 to 3 pick 1.5k, 6k, 12k, 24k ohm.
// - Open-drain pads drive low data, enable follows the module signal.
// - A pad with input disabled presents zero.
module serial_master_pad_routing #(
    parameter NPADS = `PAD_COUNT
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Pad configuration, pad n in field n
    input wire [NPADS*`FSEL_W-1:0] pad_function_select,
    input wire [NPADS-1:0] pad_input_enable,
    input wire [NPADS-1:0] pad_pullup_enable,
    input wire [NPADS*`PSIZE_W-1:0] pad_pullup_size,
    // Two-wire masters 0 to 5, low output pulls the line
    input wire [5:0] i2c_scl_out,
    input wire [5:0] i2c_sda_out,
    output reg [5:0] i2c_scl_in_r,
    output reg [5:0] i2c_sda_in_r,
    // Four-wire SPI masters 0 to 3
    input wire [3:0] spi_sck,
    input wire [3:0] spi_mosi,
    output reg [3:0] spi_miso_r,
    input wire [31:0] slave_select_n,
    // Pads
    input wire [NPADS-1:0] pad_in,
    output wire [NPADS-1:0] pad_out,
    output wire [NPADS-1:0] pad_oe_n,
    output wire [NPADS*`PRES_W-1:0] pad_pullup_res,
    output wire [NPADS-1:0] pad_in_value
);

    reg [NPADS*`FSEL_WAYS-1:0] cand_data;
    reg [NPADS*`FSEL_WAYS-1:0] cand_en;
    reg [NPADS*`FSEL_WAYS-1:0] cand_od;
    reg [5:0] i2c_scl_in_nxt;
    reg [5:0] i2c_sda_in_nxt;
    reg [3:0] spi_miso_nxt;
    genvar g;

    ////////////////////////////////////////////////////////////////////////
    // True when pad p has function select f and a live input
    function hit;
        input [NPADS*`FSEL_W-1:0] fs;
        input [NPADS-1:0] vin;
        input integer p;
        input [`FSEL_W-1:0] f;
        begin
            hit = (fs[p*`FSEL_W +: `FSEL_W] == f) & vin[p];
        end
    endfunction

    // Place a module output at pad p, select f
    task put;
        input integer p;
        input integer f;
        input val;
        input od;
        begin
            cand_data[p*`FSEL_WAYS+f] = val;
            cand_en[p*`FSEL_WAYS+f] = 1'b1;
            cand_od[p*`FSEL_WAYS+f] = od;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Output routing table
    always @* begin
        cand_data = {NPADS*`FSEL_WAYS{1'b0}};
        cand_en = {NPADS*`FSEL_WAYS{1'b0}};
        cand_od = {NPADS*`FSEL_WAYS{1'b0}};
        // Two-wire masters, open drain
        put(5, 0, i2c_scl_out[0], 1'b1);
        put(6, 0, i2c_sda_out[0], 1'b1);
        put(8, 0, i2c_scl_out[1], 1'b1);
        put(9, 0, i2c_sda_out[1], 1'b1);
        put(0, 7, i2c_scl_out[2], 1'b1);
        put(1, 7, i2c_sda_out[2], 1'b1);
        put(27, 4, i2c_scl_out[2], 1'b1);
        put(25, 4, i2c_sda_out[2], 1'b1);
        put(42, 4, i2c_scl_out[3], 1'b1);
        put(43, 4, i2c_sda_out[3], 1'b1);
        put(39, 4, i2c_scl_out[4], 1'b1);
        put(40, 4, i2c_sda_out[4], 1'b1);
        put(48, 4, i2c_scl_out[5], 1'b1);
        put(49, 4, i2c_sda_out[5], 1'b1);
        // SPI clocks and MOSI, push-pull
        put(5, 1, spi_sck[0], 1'b0);
        put(7, 1, spi_mosi[0], 1'b0);
        put(8, 1, spi_sck[1], 1'b0);
        put(10, 1, spi_mosi[1], 1'b0);
        put(0, 5, spi_sck[2], 1'b0);
        put(27, 5, spi_sck[2], 1'b0);
        put(2, 5, spi_mosi[2], 1'b0);
        put(28, 5, spi_mosi[2], 1'b0);
        put(42, 5, spi_sck[3], 1'b0);
        put(38, 5, spi_mosi[3], 1'b0);
        // Master 0 slave selects, each select line shared by two to four pads
        put(11, 1, slave_select_n[0], 1'b0);
        put(23, 1, slave_select_n[0], 1'b0);
        put(42, 1, slave_select_n[0], 1'b0);
        put(17, 1, slave_select_n[1], 1'b0);
        put(24, 1, slave_select_n[1], 1'b0);
        put(43, 1, slave_select_n[1], 1'b0);
        put(18, 1, slave_select_n[2], 1'b0);
        put(25, 1, slave_select_n[2], 1'b0);
        put(44, 1, slave_select_n[2], 1'b0);
        put(19, 1, slave_select_n[3], 1'b0);
        put(26, 1, slave_select_n[3], 1'b0);
        put(45, 1, slave_select_n[3], 1'b0);
        put(8, 2, slave_select_n[4], 1'b0);
        put(16, 1, slave_select_n[4], 1'b0);
        put(31, 1, slave_select_n[4], 1'b0);
        put(46, 1, slave_select_n[4], 1'b0);
        put(4, 2, slave_select_n[5], 1'b0);
        put(9, 2, slave_select_n[5], 1'b0);
        put(32, 1, slave_select_n[5], 1'b0);
        put(47, 1, slave_select_n[5], 1'b0);
        put(10, 2, slave_select_n[6], 1'b0);
        put(33, 1, slave_select_n[6], 1'b0);
        put(48, 1, slave_select_n[6], 1'b0);
        put(34, 1, slave_select_n[7], 1'b0);
        put(49, 1, slave_select_n[7], 1'b0);
        // Master 1 slave selects
        put(6, 5, slave_select_n[8], 1'b0);
        put(12, 1, slave_select_n[8], 1'b0);
        put(35, 1, slave_select_n[8], 1'b0);
        put(7, 7, slave_select_n[9], 1'b0);
        put(13, 1, slave_select_n[9], 1'b0);
        put(36, 1, slave_select_n[9], 1'b0);
        put(5, 7, slave_select_n[10], 1'b0);
        put(14, 1, slave_select_n[10], 1'b0);
        put(37, 1, slave_select_n[10], 1'b0);
        put(15, 1, slave_select_n[11], 1'b0);
        put(38, 1, slave_select_n[11], 1'b0);
        put(3, 2, slave_select_n[12], 1'b0);
        put(27, 1, slave_select_n[12], 1'b0);
        put(20, 1, slave_select_n[13], 1'b0);
        put(28, 1, slave_select_n[13], 1'b0);
        put(21, 1, slave_select_n[14], 1'b0);
        put(29, 1, slave_select_n[14], 1'b0);
        put(22, 1, slave_select_n[15], 1'b0);
        put(30, 1, slave_select_n[15], 1'b0);
        // Master 2 slave selects
        put(3, 5, slave_select_n[16], 1'b0);
        put(26, 4, slave_select_n[16], 1'b0);
        put(36, 5, slave_select_n[16], 1'b0);
        put(14, 4, slave_select_n[17], 1'b0);
        put(24, 0, slave_select_n[17], 1'b0);
        put(41, 0, slave_select_n[17], 1'b0);
        put(15, 4, slave_select_n[18], 1'b0);
        put(42, 0, slave_select_n[18], 1'b0);
        put(13, 4, slave_select_n[19], 1'b0);
        put(16, 4, slave_select_n[19], 1'b0);
        put(34, 2, slave_select_n[19], 1'b0);
        put(8, 4, slave_select_n[20], 1'b0);
        put(43, 0, slave_select_n[20], 1'b0);
        put(4, 5, slave_select_n[21], 1'b0);
        put(47, 0, slave_select_n[21], 1'b0);
        put(10, 4, slave_select_n[22], 1'b0);
        put(48, 0, slave_select_n[22], 1'b0);
        put(11, 4, slave_select_n[23], 1'b0);
        put(49, 0, slave_select_n[23], 1'b0);
        // Master 3 slave selects
        put(26, 7, slave_select_n[24], 1'b0);
        put(34, 5, slave_select_n[25], 1'b0);
        put(35, 7, slave_select_n[26], 1'b0);
        put(36, 7, slave_select_n[27], 1'b0);
        put(37, 4, slave_select_n[28], 1'b0);
        put(41, 4, slave_select_n[29], 1'b0);
        put(45, 5, slave_select_n[30], 1'b0);
        put(33, 5, slave_select_n[31], 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pad multiplexer and driver
    generate
        for (g = 0; g < NPADS; g = g + 1) begin : pads
            pad_cell u_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .pad_function_select(pad_function_select[g*`FSEL_W +: `FSEL_W]),
                .pad_input_enable(pad_input_enable[g]),
                .pad_pullup_enable(pad_pullup_enable[g]),
                .pad_pullup_size(pad_pullup_size[g*`PSIZE_W +: `PSIZE_W]),
                .cand_data(cand_data[g*`FSEL_WAYS +: `FSEL_WAYS]),
                .cand_en(cand_en[g*`FSEL_WAYS +: `FSEL_WAYS]),
                .cand_od(cand_od[g*`FSEL_WAYS +: `FSEL_WAYS]),
                .pad_in(pad_in[g]),
                .pad_out_r(pad_out[g]),
                .pad_oe_n_r(pad_oe_n[g]),
                .pad_pullup_res_r(pad_pullup_res[g*`PRES_W +: `PRES_W]),
                .pad_in_gated(pad_in_value[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Input routing: OR of every pad selected for the signal
    always @* begin
        i2c_scl_in_nxt[0] = hit(pad_function_select, pad_in_value, 5, `FSEL_0);
        i2c_sda_in_nxt[0] = hit(pad_function_select, pad_in_value, 6, `FSEL_0);
        i2c_scl_in_nxt[1] = hit(pad_function_select, pad_in_value, 8, `FSEL_0);
        i2c_sda_in_nxt[1] = hit(pad_function_select, pad_in_value, 9, `FSEL_0);
        i2c_scl_in_nxt[2] = hit(pad_function_select, pad_in_value, 0, `FSEL_7)
            | hit(pad_function_select, pad_in_value, 27, `FSEL_4);
        i2c_sda_in_nxt[2] = hit(pad_function_select, pad_in_value, 1, `FSEL_7)
            | hit(pad_function_select, pad_in_value, 25, `FSEL_4);
        i2c_scl_in_nxt[3] = hit(pad_function_select, pad_in_value, 42, `FSEL_4);
        i2c_sda_in_nxt[3] = hit(pad_function_select, pad_in_value, 43, `FSEL_4);
        i2c_scl_in_nxt[4] = hit(pad_function_select, pad_in_value, 39, `FSEL_4);
        i2c_sda_in_nxt[4] = hit(pad_function_select, pad_in_value, 40, `FSEL_4);
        i2c_scl_in_nxt[5] = hit(pad_function_select, pad_in_value, 48, `FSEL_4);
        i2c_sda_in_nxt[5] = hit(pad_function_select, pad_in_value, 49, `FSEL_4);
        spi_miso_nxt[0] = hit(pad_function_select, pad_in_value, 6, `FSEL_1);
        spi_miso_nxt[1] = hit(pad_function_select, pad_in_value, 9, `FSEL_1);
        spi_miso_nxt[2] = hit(pad_function_select, pad_in_value, 1, `FSEL_5)
            | hit(pad_function_select, pad_in_value, 25, `FSEL_5);
        spi_miso_nxt[3] = hit(pad_function_select, pad_in_value, 43, `FSEL_5);
    end

    // Registered module inputs
    always @(posedge sys_clk) begin
        if (rst) begin
            i2c_scl_in_r <= 6'h00;
            i2c_sda_in_r <= 6'h00;
            spi_miso_r <= 4'h0;
        end else begin
            i2c_scl_in_r <= i2c_scl_in_nxt;
            i2c_sda_in_r <= i2c_sda_in_nxt;
            spi_miso_r <= spi_miso_nxt;
        end
    end

endmodule // serial_master_pad_routing

// ===== serial_master_pad_routing_sva.sv
`timescale 1ns/100ps
`include "pad_routing_defs.vh"

module serial_master_pad_routing_sva #(
    parameter NPADS = 50
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Pad configuration
    input wire [NPADS*`FSEL_W-1:0] pad_function_select,
    input wire [NPADS-1:0] pad_input_enable,
    input wire [NPADS-1:0] pad_pullup_enable,
    input wire [NPADS*`PSIZE_W-1:0] pad_pullup_size,
    // Module side
    input wire [5:0] i2c_scl_out,
    input wire [5:0] i2c_sda_out,
    input wire [5:0] i2c_scl_in_r,
    input wire [5:0] i2c_sda_in_r,
    input wire [3:0] spi_sck,
    input wire [3:0] spi_mosi,
    input wire [3:0] spi_miso_r,
    input wire [31:0] slave_select_n,
    // Pads
    input wire [NPADS-1:0] pad_in,
    input wire [NPADS-1:0] pad_out,
    input wire [NPADS-1:0] pad_oe_n,
    input wire [NPADS*`PRES_W-1:0] pad_pullup_res,
    input wire [NPADS-1:0] pad_in_value
);
    // Select field of one pad
    function automatic logic [2:0] fs(input int p);
        return pad_function_select[3*p+:3];
    endfunction

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    AST_RST_IDLE: assert property ($past(rst) |-> &pad_oe_n && pad_out == '0)
        else $error("pads not released after reset");
    AST_M0_SCL: assert property (fs(5) == 3'h0 |=> !pad_out[5] && pad_oe_n[5] == $past(i2c_scl_out[0]))
        else $error("pad 5 does not carry master 0 clock");
    AST_M1_SDA: assert property (fs(9) == 3'h0 |=> !pad_out[9] && pad_oe_n[9] == $past(i2c_sda_out[1]))
        else $error("pad 9 does not carry master 1 data");
    AST_M2_ALT_SCL: assert property (fs(27) == 3'h4 |=> pad_oe_n[27] == $past(i2c_scl_out[2]))
        else $error("pad 27 does not carry master 2 clock");
    AST_M0_MOSI: assert property (fs(7) == 3'h1 |=> !pad_oe_n[7] && pad_out[7] == $past(spi_mosi[0]))
        else $error("pad 7 does not drive master 0 data out");
    AST_M3_SEL7: assert property (fs(33) == 3'h5 |=> !pad_oe_n[33] && pad_out[33] == $past(slave_select_n[31]))
        else $error("pad 33 does not drive master 3 select 7");
    AST_M3_MISO: assert property (fs(43) == 3'h5 |=> spi_miso_r[3] == $past(pad_in[43] & pad_input_enable[43]))
        else $error("master 3 data in not taken from pad 43");
    AST_IN_GATE: assert property (pad_in_value == (pad_in & pad_input_enable))
        else $error("disabled pad input not forced to zero");
    AST_PULL_24K: assert property ((pad_pullup_enable[5] && pad_pullup_size[11:10] == 2'h3) [*2] |-> pad_pullup_res[23:20] == 4'h8)
        else $error("largest pull-up not selected on pad 5");
    AST_GPIO_REL: assert property (fs(12) == 3'h3 |=> pad_oe_n[12] && !pad_out[12])
        else $error("unserved select does not release pad 12");

    // Main scenarios reached
    cover property (fs(5) == 3'h0 && fs(6) == 3'h0);
    cover property (fs(7) == 3'h1);
    cover property (fs(33) == 3'h5);
endmodule // serial_master_pad_routing_sva

bind serial_master_pad_routing serial_master_pad_routing_sva #(.NPADS(NPADS)) sva (
    .sys_clk(sys_clk), .rst(rst), .pad_function_select(pad_function_select),
    .pad_input_enable(pad_input_enable), .pad_pullup_enable(pad_pullup_enable),
    .pad_pullup_size(pad_pullup_size), .i2c_scl_out(i2c_scl_out), .i2c_sda_out(i2c_sda_out),
    .i2c_scl_in_r(i2c_scl_in_r), .i2c_sda_in_r(i2c_sda_in_r), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso_r(spi_miso_r), .slave_select_n(slave_select_n),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_res(pad_pullup_res),
    .pad_in_value(pad_in_value));

// ===== pad_slave_model.sv
`timescale 1ns/100ps

module pad_slave_model #(
    parameter NPADS = 50
) (
    // Clock
    input wire sys_clk,
    // Device pad drivers
    input wire [NPADS-1:0] pad_out,
    input wire [NPADS-1:0] pad_oe_n,
    input wire [NPADS*4-1:0] pad_pullup_res,
    // Slave drive requests
    input wire [NPADS-1:0] ext_en,
    input wire [NPADS-1:0] ext_val,
    // Resolved pad level
    output logic [NPADS-1:0] pad_in
);
    logic [NPADS-1:0] float_r = '0;
    integer p;

    // Undriven pads without pull-up change every cycle
    always @(posedge sys_clk) float_r <= ~float_r;

    // Wired line: any low driver wins, else driven high or pulled up
    always @* begin
        for (p = 0; p < NPADS; p = p + 1) begin
            if ((!pad_oe_n[p] && !pad_out[p]) || (ext_en[p] && !ext_val[p]))
                pad_in[p] = 1'b0;
            else if (!pad_oe_n[p] || ext_en[p] || |pad_pullup_res[4*p+:4])
                pad_in[p] = 1'b1;
            else
                pad_in[p] = float_r[p];
        end
    end
endmodule // pad_slave_model

// ===== serial_master_pad_routing_tb.sv
`timescale 1ns/100ps

module serial_master_pad_routing_tb;
    localparam NP = 50;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [NP*3-1:0] fsel = {NP{3'h3}};
    reg [NP-1:0] ie = '0, pu = '0, ext_en = '0, ext_val = '0;
    reg [NP*2-1:0] psz = '0;
    reg [5:0] scl_o = 6'h3F, sda_o = 6'h3F;
    reg [3:0] sck = 4'h0, mosi = 4'h0;
    reg [31:0] ss_n = 32'hFFFFFFFF, rng = 32'h2EC2;
    wire [5:0] scl_i, sda_i;
    wire [3:0] miso;
    wire [NP-1:0] pad_in, pad_out, pad_oe_n, pad_in_value;
    wire [NP*4-1:0] pres;
    integer failures = 0, compares = 0, cycles = 0, e;
    // Pad, select, kind (0 scl 1 sda 2 sck 3 mosi 4 miso 5 select), master, index
    reg [23:0] tbl [0:50] = '{24'h050000, 24'h060100, 24'h080010, 24'h090110, 24'h007020,
        24'h017120, 24'h1B4020, 24'h194120, 24'h2A4030, 24'h2B4130, 24'h274040, 24'h284140,
        24'h304050, 24'h314150, 24'h051200, 24'h061400, 24'h071300, 24'h081210, 24'h091410,
        24'h0A1310, 24'h005220, 24'h025320, 24'h015420, 24'h1B5220, 24'h1C5320, 24'h195420,
        24'h2A5230, 24'h2B5430, 24'h265330, 24'h082504, 24'h042505, 24'h0A2506, 24'h0B1500,
        24'h311507, 24'h065510, 24'h077511, 24'h057512, 24'h032514, 24'h1E1517, 24'h035520,
        24'h180521, 24'h222523, 24'h1A4520, 24'h1A7530, 24'h225531, 24'h237532, 24'h247533,
        24'h254534, 24'h294535, 24'h2D5536, 24'h215537};

    always #10 sys_clk = ~sys_clk;

    serial_master_pad_routing #(.NPADS(NP)) dut (.sys_clk(sys_clk), .rst(rst),
        .pad_function_select(fsel), .pad_input_enable(ie), .pad_pullup_enable(pu),
        .pad_pullup_size(psz), .i2c_scl_out(scl_o), .i2c_sda_out(sda_o), .i2c_scl_in_r(scl_i),
        .i2c_sda_in_r(sda_i), .spi_sck(sck), .spi_mosi(mosi), .spi_miso_r(miso),
        .slave_select_n(ss_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_res(pres), .pad_in_value(pad_in_value));
    pad_slave_model #(.NPADS(NP)) slave (.sys_clk(sys_clk), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_pullup_res(pres), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task check(input [199:0] seen, input [199:0] exp, input [95:0] what);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: %0s seen %0h expected %0h", $time, what, seen, exp);
            end
        end
    endtask

    // One mapping alone on its pad, random module and slave values
    task run_entry(input [23:0] t);
        integer p, m;
        reg [3:0] kd;
        reg v, lvl;
        reg [127:0] w;
        reg [NP-1:0] eo, eoe;
        begin
            p = t[23:16];
            m = t[7:4];
            kd = t[11:8];
            @(negedge sys_clk);
            w = {rnd(), rnd(), rnd(), rnd()};
            ie = w[49:0];
            pu = w[99:50];
            {scl_o, sda_o, sck, mosi} = w[119:100];
            w = {rnd(), rnd(), rnd(), rnd()};
            psz = w[99:0];
            ext_val = w[127:78];
            ss_n = rnd();
            fsel = {NP{3'h3}};
            fsel[3*p+:3] = t[14:12];
            ie[p] = kd != 4'h3 && kd != 4'h5;
            if (kd > 4'h1) pu[p] = 1'b0;
            ext_en = '0;
            ext_en[p] = (kd < 4'h2 || kd == 4'h4) && rng[7];
            // Level taken half a cycle before the edge that loads the inputs; a floating pad toggles
            @(negedge sys_clk);
            lvl = pad_in[p] & ie[p];
            @(negedge sys_clk);
            case (kd)
                4'h0: v = scl_o[m];
                4'h1: v = sda_o[m];
                4'h2: v = sck[m];
                4'h3: v = mosi[m];
                default: v = ss_n[8*m+t[3:0]];
            endcase
            eo = '0;
            eoe = '1;
            if (kd < 4'h2) eoe[p] = v;
            else if (kd != 4'h4) begin
                eoe[p] = 1'b0;
                eo[p] = v;
            end
            check(pad_oe_n, eoe, "enable");
            check(pad_out, eo,
                "data");
            check(pad_in_value, pad_in & ie, "gated in");
            check(scl_i, (kd == 4'h0) ? lvl << m : 0, "scl in");
            check(sda_i, (kd == 4'h1) ? lvl << m : 0, "sda in");
            check(miso, (kd == 4'h4) ? lvl << m : 0, "miso");
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // Cut a hung run short
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            $display("unexpected at %0t: run too long", $time);
            test_done;
        end
    end

    // Main sequence
    initial begin
        repeat (4) @(negedge sys_clk);
        check(pad_oe_n, {NP{1'b1}}, "reset enable");
        check(pad_out, 0, "reset data");
        $display("reset values done");
        rst = 1'b0;
        for (e = 0; e < 51; e = e + 1) begin
            run_entry(tbl[e]);
            $display("mapping %0d done", e);
        end
        fsel[17:15] = 3'h0;
        for (e = 0; e < 5; e = e + 1) begin
            @(negedge sys_clk);
            pu[5] = e < 4;
            psz[11:10] = e[1:0];
            repeat (2) @(negedge sys_clk);
            check(pres[23:20], (e < 4) << e, "pull size");
        end
        $display("pull-up sizes done");
        fsel = {NP{3'h3}};
        fsel[35:33] = 3'h1;
        fsel[71:69] = 3'h1;
        fsel[128:126] = 3'h1;
        for (e = 0; e < 2; e = e + 1) begin
            ss_n[0] = e[0];
            repeat (2) @(negedge sys_clk);
            check({pad_oe_n[42], pad_oe_n[23], pad_oe_n[11], pad_out[42], pad_out[23],
                pad_out[11]}, {3'h0, {3{e[0]}}}, "shared");
        end
        $display("shared select done");
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(pad_oe_n, {NP{1'b1}}, "reset enable");
        check({sda_i, scl_i, miso}, 0, "reset inputs");
        rst = 1'b0;
        // First edge after release loads the shared select again
        @(negedge sys_clk);
        check({pad_oe_n[42], pad_oe_n[23], pad_oe_n[11], pad_out[42], pad_out[23],
            pad_out[11]}, 6'h07, "post reset");
        $display("second reset done");
        test_done;
    end
endmodule // serial_master_pad_routing_tb
